// file: src/pfgcd_pkg.sv
// constants, field layouts and carrier types for the frame generator / checker diagnostics
// assumes one 100 MHz clock shared with the phy datapath and the management port
package pfgcd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // one byte at 10 Mb/s
    localparam int unsigned BYTE_TIME_NS = 800;
    localparam int unsigned BYTE_CYCLES = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BYTE_DIV_LAST = 8'(BYTE_CYCLES - 1);

    localparam logic [15:0] OFF_RX_ERR = 16'h8008;
    localparam logic [15:0] OFF_OSZ = 16'h800E;
    localparam logic [15:0] OFF_USZ = 16'h800F;
    localparam logic [15:0] OFF_ODD = 16'h8010;
    localparam logic [15:0] OFF_ODD_PRE = 16'h8011;
    localparam logic [15:0] OFF_FALSE = 16'h8013;
    localparam logic [15:0] OFF_PATTERN_SOURCE_ENABLE = 16'h8020;
    localparam logic [15:0] OFF_CTRL = 16'h8021;
    localparam logic [15:0] OFF_CONT = 16'h8022;
    localparam logic [15:0] OFF_LEN = 16'h8025;
    localparam logic [15:0] OFF_GAP = 16'h8026;
    localparam logic [15:0] OFF_NFRM_H = 16'h8027;
    localparam logic [15:0] OFF_NFRM_L = 16'h8028;
    localparam logic [15:0] OFF_DONE = 16'h8029;

    localparam logic [2:0] RST_PAT = 3'h1;
    localparam logic [15:0] RST_LEN = 16'h006B;
    localparam logic [15:0] RST_GAP = 16'h000C;
    localparam logic [15:0] RST_NFRM_H = 16'h0000;
    localparam logic [15:0] RST_NFRM_L = 16'h0100;
    localparam int unsigned RESTART_BIT = 3;

    localparam logic [15:0] MAX_FRAME_BYTES = 16'h05F2;
    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
    localparam logic [15:0] PRE_LAST = 16'h0007;
    localparam logic [15:0] HDR_LAST = 16'h000D;
    localparam logic [15:0] FCS_LAST = 16'h0003;
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [7:0] ALT_BYTE = 8'h55;
    localparam logic [7:0] DEC_START = 8'hFF;
    localparam logic [47:0] DST_ADDR = 48'hFFFFFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    localparam int unsigned N_ERR = 5;
    localparam int unsigned ERR_OSZ = 0;
    localparam int unsigned ERR_USZ = 1;
    localparam int unsigned ERR_ODD = 2;
    localparam int unsigned ERR_ODD_PRE = 3;
    localparam int unsigned ERR_FALSE = 4;

    typedef enum logic [2:0] {
        PAT_STOP = 3'h0,
        PAT_RAND = 3'h1,
        PAT_ZERO = 3'h2,
        PAT_ONES = 3'h3,
        PAT_ALT = 3'h4,
        PAT_DEC = 3'h5
    } pfgcd_pat_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PRE = 6'h02,
        ST_HDR = 6'h04,
        ST_DATA = 6'h08,
        ST_FCS = 6'h10,
        ST_GAP = 6'h20
    } pfgcd_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pfgcd_mgmt_req_t;

    typedef struct packed {
        logic dv;
        logic nib_valid;
        logic sfd;
        logic bad_ssd;
    } pfgcd_rx_obs_t;

    typedef struct packed {
        logic en;
        logic [7:0] data;
    } pfgcd_tx_byte_t;
endpackage : pfgcd_pkg

// file: src/pfgcd_err_bank.sv
// bank of live error counters with latched copies taken on one snapshot strobe
// assumes increments and snapshot come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pfgcd_err_bank #(
    parameter int unsigned N = 5,
    parameter int unsigned W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] inc,
    input wire logic snap,
    output logic [N-1:0][W-1:0] latched
);
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cnt
            logic [W-1:0] live_r;
            logic [W-1:0] live_nxt;
            logic [W-1:0] copy_r;
            // each lane owns its own copy so no two processes share the output
            assign latched[g] = copy_r;
            // an event in the snapshot cycle starts the new interval, never lost
            assign live_nxt = snap ? W'(inc[g]) : live_r + W'(inc[g]);
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    live_r <= '0;
                    copy_r <= '0;
                end
                else
                begin
                    live_r <= live_nxt;
                    if (snap)
                    begin
                        copy_r <= live_r;
                    end
                end
            end
        end
    endgenerate
endmodule : pfgcd_err_bank
`default_nettype wire

// file: src/pfgcd_top.sv
// frame checker error counters, frame generator and phy transmit source select
// assumes rx observations and mac bytes come from same-clock phy logic
`timescale 1ns/1ps
`default_nettype none
module pfgcd_top #(
    parameter logic [47:0] SRC_ADDR = 48'h020000000001 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pfgcd_pkg::pfgcd_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic diagnostic_clock_enable,
    input wire pfgcd_pkg::pfgcd_rx_obs_t rx_obs,
    input wire pfgcd_pkg::pfgcd_tx_byte_t mac_tx,
    output pfgcd_pkg::pfgcd_tx_byte_t phy_tx,
    output logic gen_selected
);
    import pfgcd_pkg::*;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction : hit

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // management decode
    logic wr_en;
    logic rd_en;
    logic [15:0] wd;
    assign wr_en = mgmt_req.wr;
    assign rd_en = mgmt_req.rd;
    assign wd = mgmt_req.wdata;

    logic pattern_source_enable_r;
    logic [2:0] pat_r;
    logic restart_r;
    logic cont_r;
    logic [15:0] len_r;
    logic [15:0] gap_r;
    logic [15:0] nfrm_h_r;
    logic [15:0] nfrm_l_r;
    logic done_r;
    logic [15:0] tally_r;

    // checker
    logic dv_q_r;
    logic in_data_r;
    logic [7:0] pre_nib_r;
    logic [15:0] data_nib_r;
    logic [15:0] rx_bytes;
    logic frame_end;
    logic nib_in;
    logic [N_ERR-1:0] err_inc;
    logic snap;
    logic [N_ERR-1:0][15:0] err_latched;

    assign nib_in = rx_obs.dv & rx_obs.nib_valid;
    assign frame_end = dv_q_r & ~rx_obs.dv & in_data_r;
    assign rx_bytes = {1'b0, data_nib_r[15:1]};
    assign err_inc[ERR_OSZ] = frame_end & (rx_bytes > MAX_FRAME_BYTES);
    assign err_inc[ERR_USZ] = frame_end & (rx_bytes < MIN_FRAME_BYTES);
    assign err_inc[ERR_ODD] = frame_end & data_nib_r[0];
    assign err_inc[ERR_ODD_PRE] = rx_obs.sfd & ~in_data_r & pre_nib_r[0];
    assign err_inc[ERR_FALSE] = rx_obs.bad_ssd;
    assign snap = rd_en & hit(mgmt_req.addr, OFF_RX_ERR);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dv_q_r <= 1'b0;
            in_data_r <= 1'b0;
            pre_nib_r <= '0;
            data_nib_r <= '0;
            tally_r <= '0;
        end
        else
        begin
            dv_q_r <= rx_obs.dv;
            if (!rx_obs.dv)
            begin
                in_data_r <= 1'b0;
                pre_nib_r <= '0;
                data_nib_r <= '0;
            end
            else if (rx_obs.sfd)
            begin
                in_data_r <= 1'b1;
            end
            else if (nib_in && in_data_r && data_nib_r != 16'hFFFF)
            begin
                data_nib_r <= data_nib_r + 16'h0001;
            end
            else if (nib_in && !in_data_r)
            begin
                pre_nib_r <= pre_nib_r + 8'h01;
            end
            // self-clearing tally; an error in the read cycle is kept
            tally_r <= (snap ? 16'h0000 : tally_r) + 16'(|err_inc);
        end
    end

    pfgcd_err_bank #(
        .N(N_ERR),
        .W(16)
    ) u_err_bank (
        .clk(clk),
        .rst_n(rst_n),
        .inc(err_inc),
        .snap(snap),
        .latched(err_latched)
    );

    // generator
    pfgcd_state_t state_r;
    logic [7:0] div_r;
    logic tick;
    logic pattern_source_enable_q_r;
    logic run_r;
    logic [31:0] left_r;
    logic [15:0] idx_r;
    logic [31:0] crc_r;
    logic [15:0] lfsr_r;
    logic [7:0] dec_r;
    pfgcd_pat_t frame_pat_r;
    logic done_set;
    logic start;
    logic gen_ok;
    logic [7:0] hdr_byte;
    logic [7:0] data_byte;
    logic [7:0] gen_byte;
    logic [95:0] hdr_bits;
    logic last_gap;
    logic burst_out;

    assign tick = div_r == BYTE_DIV_LAST;
    // generator starts no new frame without the diagnostic clock; a frame in flight still finishes
    assign gen_ok = pattern_source_enable_r & diagnostic_clock_enable;
    assign start = gen_ok & ((pattern_source_enable_r & ~pattern_source_enable_q_r) | restart_r);
    assign burst_out = ~cont_r & (left_r == 32'h0000_0000);
    assign hdr_bits = {DST_ADDR, SRC_ADDR};
    assign hdr_byte = (idx_r == HDR_LAST - 16'h0001) ? len_r[15:8] :
        (idx_r == HDR_LAST) ? len_r[7:0] :
        hdr_bits[8'(95 - 8 * idx_r[3:0]) -: 8];
    assign data_byte = (frame_pat_r == PAT_RAND) ? lfsr_r[7:0] :
        (frame_pat_r == PAT_ONES) ? 8'hFF :
        (frame_pat_r == PAT_ALT) ? ALT_BYTE :
        (frame_pat_r == PAT_DEC) ? dec_r : 8'h00;
    assign gen_byte = (state_r == ST_PRE) ? ((idx_r == PRE_LAST) ? SFD_BYTE : PRE_BYTE) :
        (state_r == ST_HDR) ? hdr_byte :
        (state_r == ST_DATA) ? data_byte :
        (state_r == ST_FCS) ? ~crc_r[8 * idx_r[1:0] +: 8] : 8'h00;
    assign last_gap = ({1'b0, idx_r} + 17'h00001) >= {1'b0, gap_r};
    assign done_set = tick & (state_r == ST_IDLE) & run_r & burst_out;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r <= '0;
            pattern_source_enable_q_r <= 1'b0;
            run_r <= 1'b0;
            left_r <= '0;
        end
        else
        begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            pattern_source_enable_q_r <= pattern_source_enable_r;
            if (start)
            begin
                run_r <= 1'b1;
                left_r <= {nfrm_h_r, nfrm_l_r};
            end
            else if (done_set || !pattern_source_enable_r)
            begin
                run_r <= 1'b0;
            end
            else if (tick && state_r == ST_FCS && idx_r == FCS_LAST && !cont_r
                && left_r != 32'h0000_0000)
            begin
                left_r <= left_r - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            crc_r <= '0;
            lfsr_r <= LFSR_SEED;
            dec_r <= DEC_START;
            frame_pat_r <= PAT_STOP;
        end
        else if (tick)
        begin
            idx_r <= idx_r + 16'h0001;
            case (state_r)
                ST_IDLE:
                begin
                    idx_r <= '0;
                    // stop pattern, disable or spent burst: no new frame
                    if (run_r && gen_ok && !burst_out && pat_r != PAT_STOP)
                    begin
                        state_r <= ST_PRE;
                        frame_pat_r <= pfgcd_pat_t'(pat_r);
                    end
                end
                ST_PRE:
                begin
                    if (idx_r == PRE_LAST)
                    begin
                        state_r <= ST_HDR;
                        idx_r <= '0;
                        crc_r <= 32'hFFFF_FFFF;
                        dec_r <= DEC_START;
                    end
                end
                ST_HDR:
                begin
                    crc_r <= crc_byte(crc_r, gen_byte);
                    if (idx_r == HDR_LAST)
                    begin
                        state_r <= (len_r == 16'h0000) ? ST_FCS : ST_DATA;
                        idx_r <= '0;
                    end
                end
                ST_DATA:
                begin
                    crc_r <= crc_byte(crc_r, gen_byte);
                    lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
                    dec_r <= dec_r - 8'h01;
                    if (idx_r == len_r - 16'h0001)
                    begin
                        state_r <= ST_FCS;
                        idx_r <= '0;
                    end
                end
                ST_FCS:
                begin
                    if (idx_r == FCS_LAST)
                    begin
                        state_r <= ST_GAP;
                        idx_r <= '0;
                    end
                end
                ST_GAP:
                begin
                    if (last_gap)
                    begin
                        state_r <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // transmit source: a frame in flight keeps the generator selected
    logic sel_gen;
    logic in_frame;
    pfgcd_tx_byte_t tx_nxt;
    assign in_frame = (state_r != ST_IDLE) & (state_r != ST_GAP);
    assign sel_gen = pattern_source_enable_r | in_frame;
    assign tx_nxt = sel_gen ? pfgcd_tx_byte_t'{en: in_frame, data: gen_byte} : mac_tx;

    // register file
    logic [15:0] rd_mux;
    logic [15:0] a;
    assign a = mgmt_req.addr;
    assign rd_mux = hit(a, OFF_RX_ERR) ? tally_r :
        hit(a, OFF_OSZ) ? err_latched[ERR_OSZ] :
        hit(a, OFF_USZ) ? err_latched[ERR_USZ] :
        hit(a, OFF_ODD) ? err_latched[ERR_ODD] :
        hit(a, OFF_ODD_PRE) ? err_latched[ERR_ODD_PRE] :
        hit(a, OFF_FALSE) ? err_latched[ERR_FALSE] :
        hit(a, OFF_PATTERN_SOURCE_ENABLE) ? {15'h0000, pattern_source_enable_r} :
        hit(a, OFF_CTRL) ? {12'h000, restart_r, pat_r} :
        hit(a, OFF_CONT) ? {15'h0000, cont_r} :
        hit(a, OFF_LEN) ? len_r :
        hit(a, OFF_GAP) ? gap_r :
        hit(a, OFF_NFRM_H) ? nfrm_h_r :
        hit(a, OFF_NFRM_L) ? nfrm_l_r :
        hit(a, OFF_DONE) ? {15'h0000, done_r} : 16'h0000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pattern_source_enable_r <= 1'b0;
            pat_r <= RST_PAT;
            restart_r <= 1'b0;
            cont_r <= 1'b0;
            len_r <= RST_LEN;
            gap_r <= RST_GAP;
            nfrm_h_r <= RST_NFRM_H;
            nfrm_l_r <= RST_NFRM_L;
            done_r <= 1'b0;
            mgmt_rdata <= '0;
            mgmt_rvalid <= 1'b0;
            phy_tx <= '0;
            gen_selected <= 1'b0;
        end
        else
        begin
            restart_r <= wr_en & hit(a, OFF_CTRL) & wd[RESTART_BIT];
            if (wr_en && hit(a, OFF_PATTERN_SOURCE_ENABLE))
            begin
                pattern_source_enable_r <= wd[0];
            end
            if (wr_en && hit(a, OFF_CTRL))
            begin
                pat_r <= wd[2:0];
            end
            if (wr_en && hit(a, OFF_CONT))
            begin
                cont_r <= wd[0];
            end
            if (wr_en && hit(a, OFF_LEN))
            begin
                len_r <= wd;
            end
            if (wr_en && hit(a, OFF_GAP))
            begin
                gap_r <= wd;
            end
            if (wr_en && hit(a, OFF_NFRM_H))
            begin
                nfrm_h_r <= wd;
            end
            if (wr_en && hit(a, OFF_NFRM_L))
            begin
                nfrm_l_r <= wd;
            end
            // set wins over the clearing read
            done_r <= done_set | (done_r & ~(rd_en & hit(a, OFF_DONE)));
            mgmt_rvalid <= rd_en;
            if (rd_en)
            begin
                mgmt_rdata <= rd_mux;
            end
            phy_tx <= tx_nxt;
            gen_selected <= sel_gen;
        end
    end
endmodule : pfgcd_top
`default_nettype wire

// file: sim/pfgcd_properties.sv
// port assertions for the frame generator / checker diagnostics
// assumes it is bound into pfgcd_top and shares its single clock
`timescale 1ns/1ps
`default_nettype none
module pfgcd_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire pfgcd_pkg::pfgcd_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic diagnostic_clock_enable,
    input wire pfgcd_pkg::pfgcd_rx_obs_t rx_obs,
    input wire pfgcd_pkg::pfgcd_tx_byte_t mac_tx,
    input wire pfgcd_pkg::pfgcd_tx_byte_t phy_tx,
    input wire logic gen_selected
);
    import pfgcd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // cycles the current transmit value has stood while the generator owns the port
    logic [15:0] hold_r;
    pfgcd_tx_byte_t prev_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_r <= 16'h0000;
            prev_r <= '0;
        end
        else
        begin
            prev_r <= phy_tx;
            if (phy_tx != prev_r || !gen_selected)
            begin
                hold_r <= 16'h0000;
            end
            else if (hold_r != 16'hFFFF)
            begin
                hold_r <= hold_r + 16'h0001;
            end
        end
    end

    property p_rd_answer; mgmt_req.rd |=> mgmt_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_answer; !mgmt_req.rd |=> !mgmt_rvalid; endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without read");
    property p_rdata_hold; !mgmt_req.rd |=> $stable(mgmt_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_mac_pass; !gen_selected ##1 !gen_selected |-> phy_tx == $past(mac_tx); endproperty
    a_mac_pass: assert property (p_mac_pass) else $error("mac bytes not passed");
    property p_need_clk;
        !diagnostic_clock_enable && $past(!diagnostic_clock_enable)
            && !(gen_selected && phy_tx.en) |=> !(gen_selected && phy_tx.en);
    endproperty
    a_need_clk: assert property (p_need_clk) else $error("frame started without clock");
    // hand-back is legal from idle, or right after a whole byte slot of the last byte
    property p_whole_frame;
        $fell(gen_selected) |-> !$past(phy_tx.en)
            || hold_r % 16'(BYTE_CYCLES) == 16'(BYTE_CYCLES - 1);
    endproperty
    a_whole_frame: assert property (p_whole_frame) else $error("frame cut short");
    // a generated byte holds for a whole byte slot, far longer than eight cycles
    // the first owned cycle swaps mac data for idle data, which is not a byte slot
    property p_byte_holds;
        gen_selected && $past(gen_selected) && $changed(phy_tx.data)
            |=> $stable(phy_tx.data)[*8];
    endproperty
    a_byte_holds: assert property (p_byte_holds) else $error("byte too short");
    property p_pre_first; $rose(phy_tx.en) && gen_selected |-> phy_tx.data == PRE_BYTE; endproperty
    a_pre_first: assert property (p_pre_first) else $error("frame without preamble");
    property p_restart_sc;
        mgmt_req.rd && mgmt_req.addr == OFF_CTRL && !$past(mgmt_req.wr) |=> !mgmt_rdata[3];
    endproperty
    a_restart_sc: assert property (p_restart_sc) else $error("restart bit stuck");
endmodule : pfgcd_properties

bind pfgcd_top pfgcd_properties chk_u (.clk, .rst_n, .mgmt_req, .mgmt_rdata, .mgmt_rvalid,
    .diagnostic_clock_enable, .rx_obs, .mac_tx, .phy_tx, .gen_selected);
`default_nettype wire

// file: sim/pfgcd_phy_model.sv
// phy datapath and mac side model: receive observations, mac bytes, transmit monitor
// assumes the bench calls its tasks at falling edges
`timescale 1ns/1ps
`default_nettype none
module pfgcd_phy_model (
    input wire logic clk,
    input wire logic rst_n,
    output var pfgcd_pkg::pfgcd_rx_obs_t rx_obs,
    output var pfgcd_pkg::pfgcd_tx_byte_t mac_tx,
    input wire pfgcd_pkg::pfgcd_tx_byte_t phy_tx,
    input wire logic gen_selected
);
    import pfgcd_pkg::*;
    int frames = 0;
    int run = 0;
    logic [7:0] got[$];
    logic [7:0] cnt = 8'h00;
    initial
    begin
        rx_obs = '0;
        mac_tx = '0;
    end
    // mac stream keeps toggling so a stale pass-through would show
    always @(negedge clk)
    begin
        cnt <= cnt + 8'h01;
        mac_tx <= rst_n ? {cnt[2], cnt} : '0;
    end
    // one sample per byte slot, taken mid-slot
    always @(posedge clk)
    begin
        if (gen_selected && phy_tx.en)
        begin
            if (run % BYTE_CYCLES == BYTE_CYCLES / 2)
                got.push_back(phy_tx.data);
            run = run + 1;
        end
        else if (run != 0)
        begin
            frames = frames + 1;
            run = 0;
        end
    end
    task automatic clear();
        frames = 0;
        run = 0;
        got.delete();
    endtask : clear
    // pre of zero sends a lone bad start delimiter instead of a frame
    task automatic send_frame(input int pre, input int dat);
        int i;
        @(negedge clk);
        if (pre == 0)
        begin
            rx_obs.bad_ssd = 1'b1;
            @(negedge clk);
            rx_obs.bad_ssd = 1'b0;
        end
        else
        begin
            rx_obs.dv = 1'b1;
            rx_obs.nib_valid = 1'b1;
            for (i = 0; i <= pre + dat; i++)
            begin
                rx_obs.sfd = (i == pre);
                @(negedge clk);
            end
            rx_obs = '0;
        end
        repeat (4) @(negedge clk);
    endtask : send_frame
endmodule : pfgcd_phy_model
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the frame checker counters and frame generator
// assumes the phy model owns the receive observations and mac stream
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfgcd_pkg::*;
    localparam logic [15:0] RA [10] = '{OFF_OSZ, OFF_USZ, OFF_ODD, OFF_ODD_PRE, OFF_FALSE,
        OFF_PATTERN_SOURCE_ENABLE, OFF_CTRL, OFF_CONT, OFF_NFRM_L, OFF_GAP};
    localparam logic [15:0] RV [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0001, 16'h0000, 16'h0100, 16'h000C};
    localparam int PAT [5] = '{2, 3, 4, 5, 1};
    localparam int CNT [5] = '{1, 1, 1, 2, 1};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dce = 1'b1;
    pfgcd_mgmt_req_t req = '0;
    pfgcd_rx_obs_t rx_obs;
    pfgcd_tx_byte_t mac_tx;
    pfgcd_tx_byte_t phy_tx;
    logic [15:0] rdata;
    logic rvalid;
    logic sel;
    logic [15:0] v;
    int mismatches = 0;
    int n_checks = 0;
    int i;
    int p;
    int n;
    always #5 clk = ~clk;
    pfgcd_top dut_u (.clk(clk), .rst_n(rst_n), .mgmt_req(req), .mgmt_rdata(rdata),
        .mgmt_rvalid(rvalid), .diagnostic_clock_enable(dce), .rx_obs(rx_obs),
        .mac_tx(mac_tx), .phy_tx(phy_tx), .gen_selected(sel));
    pfgcd_phy_model phy_u (.clk(clk), .rst_n(rst_n), .rx_obs(rx_obs), .mac_tx(mac_tx),
        .phy_tx(phy_tx), .gen_selected(sel));

    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic expire(input bit hit);
        if (hit)
        begin
            mismatches++;
            stop_test();
        end
    endtask : expire
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        int k;
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        for (k = 0; k < 4 && rvalid !== 1'b1; k++)
            @(negedge clk);
        expire(k == 4);
        d = rdata;
        @(negedge clk);
    endtask : rd
    task automatic rchk(input string what, input logic [15:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(what, v, exp);
    endtask : rchk
    task automatic wait_done();
        int k;
        v = 16'h0000;
        for (k = 0; k < 3000 && v !== 16'h0001; k++)
            rd(OFF_DONE, v);
        expire(v !== 16'h0001);
    endtask : wait_done
    function automatic logic [7:0] exp_data(input int pat, input int k);
        case (pat)
            3: return 8'hFF;
            4: return ALT_BYTE;
            5: return 8'(DEC_START - 8'(k));
            default: return 8'h00;
        endcase
    endfunction : exp_data

    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        wr(OFF_OSZ, 16'hFFFF);
        for (i = 0; i < 10; i++)
            rchk("reset value", RA[i], RV[i]);
        rchk("unmapped", 16'h8030, 16'h0000);
        phy_u.send_frame(15, 130);
        phy_u.send_frame(16, 3046);
        phy_u.send_frame(16, 3044);
        phy_u.send_frame(16, 126);
        phy_u.send_frame(16, 128);
        phy_u.send_frame(16, 131);
        phy_u.send_frame(0, 0);
        phy_u.send_frame(0, 0);
        rchk("oversize before snapshot", OFF_OSZ, 16'h0000);
        rchk("error tally", OFF_RX_ERR, 16'h0006);
        rchk("oversize", OFF_OSZ, 16'h0001);
        rchk("undersize", OFF_USZ, 16'h0001);
        rchk("odd nibble", OFF_ODD, 16'h0001);
        rchk("odd preamble", OFF_ODD_PRE, 16'h0001);
        rchk("false carrier", OFF_FALSE, 16'h0002);
        rchk("tally cleared", OFF_RX_ERR, 16'h0000);
        wr(OFF_LEN, 16'h0004);
        wr(OFF_GAP, 16'h0002);
        dce = 1'b0;
        wr(OFF_NFRM_L, 16'h0001);
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0001);
        repeat (200) @(negedge clk);
        chk("selected without clock", {15'h0000, sel}, 16'h0001);
        chk("no frame without clock", 16'(phy_u.got.size()), 16'h0000);
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0000);
        dce = 1'b1;
        for (p = 0; p < 5; p++)
        begin
            phy_u.clear();
            wr(OFF_NFRM_L, 16'(CNT[p]));
            wr(OFF_CTRL, 16'(PAT[p]));
            wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0001);
            wait_done();
            rchk("done cleared", OFF_DONE, 16'h0000);
            chk("frames", 16'(phy_u.frames), 16'(CNT[p]));
            chk("bytes", 16'(phy_u.got.size()), 16'(CNT[p] * 30));
            chk("sfd", {8'h00, phy_u.got[7]}, {8'h00, SFD_BYTE});
            chk("length field", {8'h00, phy_u.got[21]}, 16'h0004);
            for (i = 0; i < 4 && PAT[p] != 1; i++)
                chk("data", {8'h00, phy_u.got[22 + i]}, {8'h00, exp_data(PAT[p], i)});
            wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0000);
        end
        phy_u.clear();
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0001);
        wait_done();
        wr(OFF_CTRL, 16'h000D);
        rchk("restart self-clears", OFF_CTRL, 16'h0005);
        wait_done();
        chk("frames after restart", 16'(phy_u.frames), 16'h0002);
        phy_u.clear();
        wr(OFF_CONT, 16'h0001);
        // continuous mode only runs from a fresh start
        wr(OFF_CTRL, 16'h000B);
        for (i = 0; i < 20000 && phy_u.frames < 3; i++)
            @(negedge clk);
        expire(i == 20000);
        chk("continuous frames", 16'(phy_u.frames), 16'h0003);
        wr(OFF_CTRL, 16'h0000);
        repeat (6000) @(negedge clk);
        n = phy_u.frames;
        repeat (3000) @(negedge clk);
        chk("stopped by pattern", 16'(phy_u.frames), 16'(n));
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0000);
        phy_u.clear();
        wr(OFF_CTRL, 16'h0002);
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0001);
        for (i = 0; i < 2000 && phy_u.run < 300; i++)
            @(negedge clk);
        expire(i == 2000);
        wr(OFF_PATTERN_SOURCE_ENABLE, 16'h0000);
        for (i = 0; i < 4000 && sel !== 1'b0; i++)
            @(negedge clk);
        expire(i == 4000);
        chk("frame finished", 16'(phy_u.got.size()), 16'h001E);
        stop_test();
    end
endmodule : tb
`default_nettype wire
